// ---- hw/tlb_regs.svh ----
`ifndef TLB_ACCESS_REGS_SVH
`define TLB_ACCESS_REGS_SVH
`define NUM_ENTRIES 64
`define LAST_ENTRY 6'h3f
`define ASI_DATA_IN_DEF 8'h5c
`define ASI_DATA_ACC_DEF 8'h5d
`define ASI_TAG_READ_DEF 8'h5e
`define ASI_DEMAP_DEF 8'h5f
`define VA_FMT_BIT 10
`define VA_REAL_BIT 9
`define VA_IDX_HI 8
`define VA_IDX_LO 3
`define DM_TYPE_HI 7
`define DM_TYPE_LO 6
`define DM_CTX_HI 5
`define DM_CTX_LO 4
`define VPN_HI 47
`define VPN_LO 13
`define CTX_HI 12
`define CTX_LO 0
`define D_VALID 63
`define PA_HI 39
`define PA_LO 13
`define LG_SZ_HI 62
`define LG_SZ_LO 61
`define LG_SZ2 48
`define LG_LOCK 6
`define LG_ATTR_HI 5
`define LG_ATTR_LO 0
`define EX_SZ_HI 3
`define EX_SZ_LO 0
`define EX_LOCK 61
`define EX_ATTR_HI 11
`define EX_ATTR_LO 6
`define MAX_LG_SZ 3'h3
`define MAX_EX_SZ 4'h3
`define MUX_8K 3'h7
`define MUX_64K 3'h6
`define MUX_4M 3'h4
`define MUX_256M 3'h0
`define MASK_64K 35'h7
`define MASK_4M 35'h1ff
`define MASK_256M 35'h7fff
`define TR_PID_HI 63
`define TR_MUX_HI 58
`define TR_MUX_LO 56
`endif

// ---- hw/tlb_pkg.sv ----
package tlb_pkg;
  typedef logic [5:0] entry_idx_t;
  typedef enum logic [1:0] {DM_PAGE = 2'b00, DM_CTX = 2'b01, DM_ALL = 2'b10, DM_RSVD = 2'b11} demap_type_t;
  typedef enum logic [1:0] {CS_PRIMARY = 2'b00, CS_SECONDARY = 2'b01, CS_NUCLEUS = 2'b10, CS_RSVD = 2'b11} ctx_sel_t;
  typedef enum logic [1:0] {PS_8K = 2'b00, PS_64K = 2'b01, PS_4M = 2'b10, PS_256M = 2'b11} page_size_t;
endpackage : tlb_pkg

// ---- hw/tlb_access_and_demap.sv ----
`timescale 1ns/100ps
`include "tlb_regs.svh"
// Functional notes
// RULE1: VA bit 10 selects extended write format
// RULE2: Entry real bit comes from VA bit 9
// RULE3: Remove every overlapping entry before insert
// RULE4: Autodemap needs equal pid, real, context
// RULE5: Autodemap also removes locked entries
// RULE6: Reserved page size traps on write
// RULE7: Invalid replacement still allocates and autodemaps
// RULE8: All locked and valid: replace entry 63
// RULE9: Entry index from VA bits 8:3
// RULE10: Tag read field layout pid real parity
// RULE11: Parity over tag fields and lock copy
// RULE12: Size mux codes 000 100 110 111
// RULE13: Keep offset bits, sign-extend bits 55:48
// RULE14: Directed write: data from store, tag-access tag
// RULE15: Replacement write goes to replacement pointer
// RULE16: Data read always in legacy format
// RULE17: Tag read returns only tag portion
// RULE18: Load from replacement register traps
// RULE19: Demap only touches current partition entries
// RULE20: Demap is 64-bit store to demap space
// RULE21: Demap type and real bit decode
// RULE22: Demap context select; page ignored otherwise
// RULE23: Trapping access changes no TLB state
module tlb_access_and_demap #(
  parameter logic [7:0] ASI_DATA_IN = `ASI_DATA_IN_DEF,
  parameter logic [7:0] ASI_DATA_ACC = `ASI_DATA_ACC_DEF,
  parameter logic [7:0] ASI_TAG_READ = `ASI_TAG_READ_DEF,
  parameter logic [7:0] ASI_DEMAP = `ASI_DEMAP_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_store,
  input wire logic [7:0] req_asi,
  input wire logic [63:0] req_va,
  input wire logic [63:0] req_wdata,
  input wire logic [63:0] tag_access,
  input wire logic [2:0] partition_id,
  input wire logic [12:0] primary_ctx,
  input wire logic [12:0] secondary_ctx,
  input wire tlb_pkg::entry_idx_t repl_ptr,
  output logic resp_valid,
  output logic resp_trap,
  output logic [63:0] resp_rdata,
  output logic [63:0] entry_valid,
  output logic [63:0] entry_locked
);
  import tlb_pkg::*;

  // Offset bits to ignore for each page size
  function automatic logic [34:0] size_mask(input logic [1:0] sz);
    case (page_size_t'(sz))
      PS_64K: size_mask = `MASK_64K;
      PS_4M: size_mask = `MASK_4M;
      PS_256M: size_mask = `MASK_256M;
      default: size_mask = 35'h0;
    endcase
  endfunction : size_mask

  // Size to tag-read multiplexor code
  function automatic logic [2:0] mux_code(input logic [1:0] sz);
    case (page_size_t'(sz))
      PS_64K: mux_code = `MUX_64K;
      PS_4M: mux_code = `MUX_4M;
      PS_256M: mux_code = `MUX_256M;
      default: mux_code = `MUX_8K;
    endcase
  endfunction : mux_code

  // Offset bits below the coarser page are stored but never compared
  function automatic logic vpn_match(input logic [34:0] a, input logic [34:0] b, input logic [34:0] ign);
    vpn_match = ((a ^ b) & ~ign) == 35'h0;
  endfunction : vpn_match

  logic [63:0] v_q;
  logic [63:0] lock_q;
  logic [63:0] real_q;
  logic [2:0] pid_q [`NUM_ENTRIES];
  logic [1:0] sz_q [`NUM_ENTRIES];
  logic [34:0] va_q [`NUM_ENTRIES];
  logic [12:0] ctx_q [`NUM_ENTRIES];
  logic [26:0] pa_q [`NUM_ENTRIES];
  logic [5:0] attr_q [`NUM_ENTRIES];
  logic resp_valid_q;
  logic resp_trap_q;
  logic [63:0] rdata_q;
  logic [63:0] rdata_d;

  wire acc_din = req_valid && (req_asi == ASI_DATA_IN);
  wire acc_dacc = req_valid && (req_asi == ASI_DATA_ACC);
  wire acc_tagrd = req_valid && (req_asi == ASI_TAG_READ);
  wire acc_dm = req_valid && (req_asi == ASI_DEMAP);

  wire fmt_ext = req_va[`VA_FMT_BIT]; // RULE1
  wire [3:0] ex_sz = req_wdata[`EX_SZ_HI:`EX_SZ_LO];
  wire [2:0] lg_sz = {req_wdata[`LG_SZ2], req_wdata[`LG_SZ_HI:`LG_SZ_LO]};
  wire size_rsvd = fmt_ext ? (ex_sz > `MAX_EX_SZ) : (lg_sz > `MAX_LG_SZ); // RULE6
  wire [1:0] new_sz = fmt_ext ? ex_sz[1:0] : lg_sz[1:0]; // RULE1
  wire new_lock = fmt_ext ? req_wdata[`EX_LOCK] : req_wdata[`LG_LOCK];
  wire [5:0] new_attr = fmt_ext ? req_wdata[`EX_ATTR_HI:`EX_ATTR_LO] : req_wdata[`LG_ATTR_HI:`LG_ATTR_LO];
  wire new_valid = req_wdata[`D_VALID];
  wire new_real = req_va[`VA_REAL_BIT]; // RULE2
  wire [34:0] new_vpn = tag_access[`VPN_HI:`VPN_LO]; // RULE14
  wire [12:0] new_ctx = tag_access[`CTX_HI:`CTX_LO];

  wire wr_access = (acc_din || acc_dacc) && req_store;
  wire do_write = wr_access && !size_rsvd; // RULE23
  wire do_autodemap = do_write && acc_din;
  // Reserved page sizes trap here rather than write garbage into the array
  wire trap_d = (wr_access && size_rsvd) || (acc_din && !req_store) // RULE6 RULE18
    || (acc_tagrd && req_store) || (acc_dm && !req_store);

  // Unknown spaces answer without a trap; the strand decides what to do
  wire all_lv = &(v_q & lock_q);
  wire entry_idx_t va_idx = req_va[`VA_IDX_HI:`VA_IDX_LO]; // RULE9
  // Locked-full TLB would otherwise let the pointer land on a pinned entry
  wire entry_idx_t wr_idx = acc_din ? (all_lv ? `LAST_ENTRY : repl_ptr) : va_idx; // RULE8 RULE15

  wire demap_type_t dm_type = demap_type_t'(req_va[`DM_TYPE_HI:`DM_TYPE_LO]); // RULE21
  wire ctx_sel_t dm_csel = ctx_sel_t'(req_va[`DM_CTX_HI:`DM_CTX_LO]); // RULE22
  wire dm_real = req_va[`VA_REAL_BIT] && (dm_type == DM_PAGE); // RULE21
  // Nucleus context is always zero
  wire [12:0] dm_ctx = (dm_csel == CS_PRIMARY) ? primary_ctx :
    (dm_csel == CS_SECONDARY) ? secondary_ctx : 13'h0; // RULE22
  // A reserved type, or a reserved context for page and context demaps, is a no-op
  wire do_demap = acc_dm && req_store && (dm_type != DM_RSVD) // RULE20
    && ((dm_type == DM_ALL) || (dm_csel != CS_RSVD));
  // Bits 63:48 are never checked; page number only used by page demap
  wire [34:0] dm_vpn = req_va[`VPN_HI:`VPN_LO]; // RULE22

  logic [63:0] ovl_hit;
  logic [63:0] dm_hit;
  logic [63:0] clr;
  genvar g;
  for (g = 0; g < `NUM_ENTRIES; g++) begin : g_match
    wire pid_eq = pid_q[g] == partition_id; // RULE19
    wire ovl_va = vpn_match(va_q[g], new_vpn, size_mask(sz_q[g]) | size_mask(new_sz)); // RULE3
    // Lock is deliberately not looked at here
    assign ovl_hit[g] = v_q[g] && pid_eq && (real_q[g] == new_real) // RULE4 RULE5
      && (new_real || (ctx_q[g] == new_ctx)) && ovl_va;
    wire pg_hit = (real_q[g] == dm_real) && (dm_real || (ctx_q[g] == dm_ctx))
      && vpn_match(va_q[g], dm_vpn, size_mask(sz_q[g]));
    wire cx_hit = !real_q[g] && (ctx_q[g] == dm_ctx);
    // Demap all spares pinned entries; autodemap does not
    assign dm_hit[g] = v_q[g] && pid_eq && ((dm_type == DM_PAGE) ? pg_hit : // RULE19 RULE21
      (dm_type == DM_CTX) ? cx_hit : !lock_q[g]);
    assign clr[g] = (do_autodemap && ovl_hit[g]) || (do_demap && dm_hit[g]); // RULE3 RULE20
  end

  wire [2:0] rd_mux = mux_code(sz_q[va_idx]); // RULE12
  wire [34:0] rd_vpn = va_q[va_idx];
  // Parity is rebuilt on every read from what is stored
  wire rd_par = ^{pid_q[va_idx], real_q[va_idx], rd_mux, rd_vpn, ctx_q[va_idx], lock_q[va_idx]}; // RULE11
  wire [63:0] tag_word = {pid_q[va_idx], real_q[va_idx], rd_par, rd_mux, // RULE10 RULE17
    {8{rd_vpn[34]}}, rd_vpn, ctx_q[va_idx]}; // RULE13
  // Legacy layout; high size bit always 0 as only four sizes exist
  wire [63:0] data_word = {v_q[va_idx], sz_q[va_idx], 21'h0, pa_q[va_idx], // RULE16
    6'h0, lock_q[va_idx], attr_q[va_idx]};

  // Stores and traps return zero so a stale word never leaks
  always_comb begin
    rdata_d = 64'h0;
    if (acc_tagrd && !req_store) begin
      rdata_d = tag_word;
    end else if (acc_dacc && !req_store) begin
      rdata_d = data_word;
    end
  end

  // Clear first, then the write: a new entry beats its own autodemap
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      v_q <= 64'h0;
      lock_q <= 64'h0;
      real_q <= 64'h0;
    end else begin
      v_q <= v_q & ~clr;
      if (do_write) begin
        v_q[wr_idx] <= new_valid; // RULE7
        lock_q[wr_idx] <= new_lock;
        real_q[wr_idx] <= new_real; // RULE2
      end
    end
  end

  // Payload fields need no reset; matching only uses an entry once valid
  always_ff @(posedge clk_sys) begin
    if (do_write) begin
      pid_q[wr_idx] <= partition_id; // RULE14 RULE15
      sz_q[wr_idx] <= new_sz;
      va_q[wr_idx] <= new_vpn; // RULE13
      ctx_q[wr_idx] <= new_ctx;
      pa_q[wr_idx] <= req_wdata[`PA_HI:`PA_LO];
      attr_q[wr_idx] <= new_attr;
    end
  end

  // Every request, known space or not, gets exactly one reply
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      resp_valid_q <= 1'b0;
      resp_trap_q <= 1'b0;
      rdata_q <= 64'h0;
    end else begin
      resp_valid_q <= req_valid;
      resp_trap_q <= trap_d;
      rdata_q <= rdata_d;
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp_trap = resp_trap_q;
  assign resp_rdata = rdata_q;
  assign entry_valid = v_q;
  assign entry_locked = lock_q;

  // Step sequences shared by the trap and read checks
  sequence s_din_load;
    acc_din && !req_store;
  endsequence
  sequence s_rsvd_write;
    wr_access && size_rsvd;
  endsequence
  sequence s_trap_reply;
    resp_valid && resp_trap;
  endsequence
  sequence s_tag_load;
    acc_tagrd && !req_store;
  endsequence
  sequence s_store_req;
    req_valid && req_store;
  endsequence
  sequence s_tagrd_store;
    acc_tagrd && req_store;
  endsequence
  sequence s_rsvd_demap;
    acc_dm && req_store && (dm_type == DM_RSVD);
  endsequence

  a_din_load_trap: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE18
    s_din_load |=> s_trap_reply) else $error("load from replacement register did not trap");
  a_rsvd_size_trap: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE6
    s_rsvd_write |=> s_trap_reply) else $error("reserved page size did not trap");
  a_trap_state_kept: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE23
    trap_d |=> (entry_valid == $past(entry_valid)) && (entry_locked == $past(entry_locked)))
    else $error("trapping access changed the TLB");
  a_locked_full_victim: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE8
    do_autodemap && all_lv |=> (v_q[`LAST_ENTRY] == $past(new_valid)) && (lock_q[`LAST_ENTRY] == $past(new_lock)))
    else $error("full locked TLB did not replace last entry");
  a_real_from_addr: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE2
    do_write |=> real_q[$past(wr_idx)] == $past(req_va[`VA_REAL_BIT]))
    else $error("real bit not taken from address");
  a_invalid_entry_kept: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE7
    do_write && !new_valid |=> !v_q[$past(wr_idx)] && (lock_q[$past(wr_idx)] == $past(new_lock)))
    else $error("invalid write not stored as invalid");
  a_overlap_removed: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE3
    do_autodemap |=> (entry_valid & $past(ovl_hit) & ~(64'h1 << $past(wr_idx))) == 64'h0)
    else $error("overlapping entry survived insert");
  a_demap_removed: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE20
    do_demap |=> ((entry_valid & $past(dm_hit)) == 64'h0) && !resp_trap)
    else $error("demap left a matching entry");
  a_tag_sign_ext: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE13
    s_tag_load |=> resp_rdata[55:48] == {8{resp_rdata[47]}})
    else $error("tag read page number not sign extended");
  a_tag_pid_field: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE10
    s_tag_load |=> resp_rdata[63:60] == {$past(pid_q[va_idx]), $past(real_q[va_idx])})
    else $error("tag read pid or real field wrong");
  a_data_legacy: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE16
    acc_dacc && !req_store |=> !resp_rdata[`LG_SZ2] && (resp_rdata[`LG_LOCK] == $past(lock_q[va_idx])))
    else $error("data read not in legacy format");
  a_demap_pid_only: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE19
    do_demap && !do_write |=> ((($past(entry_valid) ^ entry_valid) & ~$past(dm_hit)) == 64'h0))
    else $error("demap touched other partition entry");

  // Reply framing: one answer per request, stores hand back no data
  a_resp_one_cycle: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE20
    resp_valid == $past(req_valid))
    else $error("reply did not follow request by one cycle");
  a_store_rdata_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE14
    s_store_req |=> resp_rdata == 64'h0)
    else $error("store returned read data");
  a_tagrd_store_trap: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE17
    s_tagrd_store |=> s_trap_reply)
    else $error("store to tag read did not trap");
  a_demap_load_trap: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE20
    acc_dm && !req_store |=> s_trap_reply)
    else $error("load from demap space did not trap");
  // Tag word parity and size code checks, then demap, directed write and format checks
  a_tag_parity_even: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE11
    s_tag_load |=> (^{resp_rdata[`TR_PID_HI:`TR_MUX_LO], resp_rdata[`VPN_HI:`CTX_LO],
    $past(lock_q[va_idx])}) == 1'b0)
    else $error("tag read parity does not cover its fields");
  a_tag_mux_code: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE12
    s_tag_load |=> resp_rdata[`TR_MUX_HI:`TR_MUX_LO] inside {`MUX_8K, `MUX_64K, `MUX_4M, `MUX_256M})
    else $error("tag read size code not a legal encoding");
  a_rsvd_demap_noop: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE21
    s_rsvd_demap |=> (entry_valid == $past(entry_valid)) && !resp_trap)
    else $error("reserved demap type changed the TLB");
  a_directed_index: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE9
    acc_dacc && do_write |=> v_q[$past(va_idx)] == $past(new_valid))
    else $error("directed write missed the addressed entry");
  a_format_lock_bit: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE1
    do_write |=> lock_q[$past(wr_idx)] == $past(fmt_ext ? req_wdata[`EX_LOCK] : req_wdata[`LG_LOCK]))
    else $error("lock bit not taken from the selected format");
endmodule : tlb_access_and_demap

// ---- verif/strand_model.sv ----
`timescale 1ns/100ps
module strand_model (
  input wire logic clk_sys,
  input wire logic resp_valid,
  input wire logic resp_trap,
  input wire logic [63:0] resp_rdata,
  output logic req_valid,
  output logic req_store,
  output logic [7:0] req_asi,
  output logic [63:0] req_va,
  output logic [63:0] req_wdata
);
  logic got;
  logic trap;
  logic [63:0] rdata;
  initial begin
    req_valid = 1'b0;
    req_store = 1'b0;
    req_asi = 8'h00;
    req_va = 64'h0;
    req_wdata = 64'h0;
  end
  // Every access is one 64-bit word; demap goes out as a plain store
  task automatic issue(input logic st, input logic [7:0] asi, input logic [63:0] va, input logic [63:0] wd);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_store = st;
    req_asi = asi;
    req_va = va;
    req_wdata = wd;
    got = 1'b0;
    for (int k = 0; k < 3 && !got; k++) begin
      @(negedge clk_sys);
      if (k == 0) begin
        req_valid = 1'b0;
        // Released address and data lines carry junk, not the old value
        req_va = ~va;
        req_wdata = ~wd;
      end
      if (resp_valid === 1'b1) begin
        got = 1'b1;
        trap = resp_trap;
        rdata = resp_rdata;
      end
    end
  endtask : issue
endmodule : strand_model

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import tlb_pkg::*;
  logic clk_sys, resetn, req_valid, req_store, resp_valid, resp_trap;
  logic [7:0] req_asi;
  logic [63:0] req_va, req_wdata, resp_rdata, tag_access, entry_valid, entry_locked, w;
  logic [2:0] partition_id;
  logic [12:0] primary_ctx, secondary_ctx;
  entry_idx_t repl_ptr;
  int num_errors, compares, cycles;
  logic [12:0] cx [6] = '{13'h5, 13'h7, 13'h9, 13'h2, 13'h0, 13'h3};
  logic [63:0] dm [5] = '{64'h100000, 64'h50, 64'hc0, 64'h60, 64'h80};
  logic [5:0] ex [5] = '{6'h3e, 6'h3c, 6'h3c, 6'h2c, 6'h0c};
  tlb_access_and_demap i_dut (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req_store(req_store),
    .req_asi(req_asi), .req_va(req_va), .req_wdata(req_wdata), .tag_access(tag_access),
    .partition_id(partition_id), .primary_ctx(primary_ctx), .secondary_ctx(secondary_ctx),
    .repl_ptr(repl_ptr), .resp_valid(resp_valid), .resp_trap(resp_trap), .resp_rdata(resp_rdata),
    .entry_valid(entry_valid), .entry_locked(entry_locked));
  strand_model i_s (.clk_sys(clk_sys), .resp_valid(resp_valid), .resp_trap(resp_trap), .resp_rdata(resp_rdata),
    .req_valid(req_valid), .req_store(req_store), .req_asi(req_asi), .req_va(req_va), .req_wdata(req_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Whole run needs well under 1000 cycles; a hang stops here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  function automatic logic [63:0] dat(input logic ext, v, input logic [3:0] sz, input logic [26:0] pa, input logic lk);
    logic [63:0] d;
    d = 64'h0;
    d[63] = v;
    d[39:13] = pa;
    if (ext) begin
      d[3:0] = sz;
      d[61] = lk;
      d[11:6] = pa[5:0];
    end else begin
      d[62:61] = sz[1:0];
      d[48] = sz[2];
      d[6] = lk;
      d[5:0] = pa[5:0];
    end
    return d;
  endfunction : dat
  // Even parity over pid, real, size code, page, context and the lock copy
  function automatic logic [63:0] tag(input logic [2:0] p, input logic r, input logic [1:0] sz, input logic [63:0] ta,
    input logic lk);
    logic [2:0] mux;
    mux = (sz == 2'd0) ? 3'h7 : (sz == 2'd1) ? 3'h6 : (sz == 2'd2) ? 3'h4 : 3'h0;
    return {p, r, ^{p, r, mux, ta[47:0], lk}, mux, {8{ta[47]}}, ta[47:0]};
  endfunction : tag
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic st, input logic [7:0] asi, input logic [63:0] va, wd, input logic trap);
    i_s.issue(st, asi, va, wd);
    chk({63'h0, i_s.got}, 64'h1);
    chk({63'h0, i_s.trap}, {63'h0, trap});
  endtask : acc
  task automatic wr(input entry_idx_t idx, input logic ext, r, input logic [3:0] sz, input logic [26:0] pa, input logic lk);
    acc(1'b1, 8'h5d, {53'h0, ext, r, idx, 3'h0}, dat(ext, 1'b1, sz, pa, lk), 1'b0);
    chk(i_s.rdata, 64'h0);
  endtask : wr
  task automatic tagchk(input entry_idx_t idx, input logic [2:0] p, input logic r, input logic [1:0] sz, input logic lk);
    acc(1'b0, 8'h5e, {55'h0, idx, 3'h0}, 64'h0, 1'b0);
    chk(i_s.rdata, tag(p, r, sz, tag_access, lk));
  endtask : tagchk
  task automatic rst();
    resetn = 1'b0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
  endtask : rst
  task automatic conclude();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    entry_idx_t idx;
    logic r, lk, ext;
    logic [1:0] sz;
    logic [26:0] pa;
    {num_errors, compares, cycles} = '0;
    {tag_access, partition_id, primary_ctx, secondary_ctx, repl_ptr} = '0;
    void'($urandom(27));
    rst();
    repeat (8) begin
      idx = 6'($urandom);
      {ext, r, lk, sz} = 5'($urandom);
      pa = 27'($urandom);
      tag_access = {$urandom, $urandom};
      partition_id = 3'($urandom);
      wr(idx, ext, r, {2'b0, sz}, pa, lk);
      chk({62'h0, entry_valid[idx], entry_locked[idx]}, {62'h0, 1'b1, lk});
      tagchk(idx, partition_id, r, sz, lk);
      acc(1'b0, 8'h5d, {55'h0, idx, 3'h0}, 64'h0, 1'b0);
      chk(i_s.rdata, dat(1'b0, 1'b1, {2'b0, sz}, pa, lk));
    end
    w = entry_valid;
    acc(1'b1, 8'h5c, 64'h400, dat(1'b1, 1'b1, 4'h9, 27'h5, 1'b0), 1'b1);
    acc(1'b0, 8'h5c, 64'h0, 64'h0, 1'b1);
    acc(1'b1, 8'h5d, {55'h0, 6'd7, 3'h0}, dat(1'b0, 1'b1, 4'h4, 27'h5, 1'b0), 1'b1);
    acc(1'b1, 8'h5e, 64'h0, 64'h0, 1'b1);
    acc(1'b0, 8'h5f, 64'h0, 64'h0, 1'b1);
    chk(entry_valid, w);
    rst();
    partition_id = 3'h1;
    tag_access = {16'h0, 35'h40, 13'h5};
    wr(6'd10, 1'b0, 1'b0, 4'h1, 27'h1, 1'b1);
    partition_id = 3'h2;
    wr(6'd11, 1'b0, 1'b0, 4'h1, 27'h2, 1'b0);
    partition_id = 3'h1;
    tag_access = {16'h0, 35'h40, 13'h6};
    wr(6'd12, 1'b0, 1'b0, 4'h1, 27'h2, 1'b0);
    tag_access = {16'h0, 35'h41, 13'h5};
    repl_ptr = 6'd20;
    acc(1'b1, 8'h5c, 64'h0, dat(1'b0, 1'b1, 4'h0, 27'h3, 1'b0), 1'b0);
    chk({60'h0, entry_valid[20], entry_valid[12:10]}, 64'he);
    repl_ptr = 6'd30;
    acc(1'b1, 8'h5c, 64'h0, dat(1'b0, 1'b0, 4'h0, 27'h3, 1'b0), 1'b0);
    chk({62'h0, entry_valid[30], entry_valid[20]}, 64'h0);
    tagchk(6'd30, 3'h1, 1'b0, 2'd0, 1'b0);
    rst();
    primary_ctx = 13'h5;
    secondary_ctx = 13'h7;
    for (int i = 0; i < 6; i++) begin
      partition_id = (i == 3) ? 3'h2 : 3'h1;
      tag_access = {16'h0, 35'(i + 128), cx[i]};
      wr(6'(i), 1'b0, 1'b0, 4'h0, 27'(i), i == 2);
    end
    partition_id = 3'h1;
    for (int j = 0; j < 5; j++) begin
      acc(1'b1, 8'h5f, dm[j], 64'h0, 1'b0);
      chk({58'h0, entry_valid[5:0]}, {58'h0, ex[j]});
    end
    tag_access = {16'h0, 35'h90, 13'h4};
    wr(6'd6, 1'b0, 1'b1, 4'h0, 27'h6, 1'b0);
    chk({63'h0, entry_valid[6]}, 64'h1);
    acc(1'b1, 8'h5f, {16'h0, 35'h90, 13'h200}, 64'h0, 1'b0);
    chk({63'h0, entry_valid[6]}, 64'h0);
    for (int i = 0; i < 64; i++) begin
      tag_access = {16'h0, 35'(i + 300), 13'h1};
      wr(6'(i), 1'b0, 1'b0, 4'h0, 27'(i), 1'b1);
    end
    repl_ptr = 6'd5;
    tag_access = {16'h0, 35'h7000, 13'h1};
    acc(1'b1, 8'h5c, 64'h0, dat(1'b0, 1'b1, 4'h0, 27'h9, 1'b1), 1'b0);
    tagchk(6'h3f, 3'h1, 1'b0, 2'd0, 1'b1);
    conclude();
  end
endmodule : testbench
